// [design/elevator_speed_supervisor.v]
// speed supervision, display scaling and three-button setup menu
// assumes synchronous inputs, one-cycle touches, nv store outside
//
// Register access over Wishbone and the address map were chosen for this implementation.
`include "elevator_speed_supervisor_defines.vh"

// Notes on behaviour
// - load saved parameters at power-up, else defaults
// - thirty idle seconds leave the menu
// - C opens menu, B moves, C enters
// - A abandons the main menu
// - setup: A/B select or step, C accepts
// - engineer access needs code B,B,B,B
// - engineer sequence starts at scale, ends save
// - factory shows code number, wider ranges
// - factory code reused until save answered yes
// - factory sequence can change engineer code
// - scale 0.01 to 99.99, default 12.00
// - display equals ppm times scale over twelve
// - scale affects display only, not trips
// - display above 9999 shows overrange
// - underspeed alarm: alarm lamp, alarm relay drops
// - underspeed stop: stop lamp, stop relay drops
// - overspeed alarm: lamp now, relay after delay
// - overspeed stop: lamp now, relay after delay
// - calibrate after interlock and start-up delay
// - sixteen second run stores averaged speed
// - interlock loss aborts calibration, drops relays
// - overspeed alarm delay one to ten seconds
// - overspeed stop delay default twenty seconds
module elevator_speed_supervisor #(
	parameter            TICKS_PER_SEC = `SEC_CYCLES,
	parameter [7:0]      FAC_KEY       = 8'h5A // arbitrary value
) (
	input  wire          clk_i,
	input  wire          rst_i,
	input  wire          ce_i,
	input  wire          wb_cyc_i,
	input  wire          wb_stb_i,
	input  wire          wb_we_i,
	input  wire [7:0]    wb_adr_i,
	input  wire [31:0]   wb_dat_i,
	input  wire [3:0]    wb_sel_i,
	output reg  [31:0]   wb_dat_o,
	output reg           wb_ack_o,
	input  wire          btn_a_i,
	input  wire          btn_b_i,
	input  wire          btn_c_i,
	input  wire          probe_i,
	input  wire          interlock_i,
	input  wire          nv_valid_i,
	input  wire          nv_blank_i,
	input  wire [50:0]   nv_data_i,
	output reg           nv_wr_o,
	output wire [50:0]   nv_wr_data_o,
	output reg  [13:0]   disp_o,
	output reg           disp_over_o,
	output wire [3:0]    menu_state_o,
	output reg           cursor_o,
	output reg  [7:0]    code_num_o,
	output reg  [2:0]    edit_idx_o,
	output reg  [15:0]   edit_val_o,
	output reg           save_yes_o,
	output reg  [6:0]    progress_o,
	output reg           alarm_lamp_o,
	output reg           stop_lamp_o,
	output reg           alarm_relay_o,
	output reg           stop_relay_o
);

	localparam [31:0] TMAX_W = TICKS_PER_SEC - 1;
	localparam [27:0] TMAX = TMAX_W[27:0];
	localparam [3:0] S_LOAD = 4'h0, S_STATUS = 4'h1, S_MAIN = 4'h2,
		S_CALCODE = 4'h3, S_WAIT_IL = 4'h4, S_STARTUP = 4'h5,
		S_CALRUN = 4'h6, S_SETSEL = 4'h7, S_ENGCODE = 4'h8,
		S_FACCODE = 4'h9, S_EDIT = 4'hA, S_SAVE = 4'hB;

	// ****************************************
	// second tick and speed measurement
	// ****************************************
	reg  [27:0] tick;
	reg         probe_q;
	reg  [9:0]  pcnt;
	reg  [15:0] ppm;
	wire        sec   = (tick == TMAX);
	wire        pedge = probe_i & ~probe_q;

	always @(posedge clk_i) begin
		if (rst_i) begin
			tick    <= 28'h0000000;
			probe_q <= 1'b0;
			pcnt    <= 10'h000;
			ppm     <= 16'h0000;
		end else if (ce_i) begin
			probe_q <= probe_i;
			tick    <= sec ? 28'h0000000 : tick + 28'h0000001;
			if (sec) begin
				ppm  <= {6'h00, pcnt} * `PPM_PER_PPS;
				pcnt <= {9'h000, pedge};
			end else if (pedge && pcnt != 10'h3FF) begin
				pcnt <= pcnt + 10'h001;
			end
		end
	end

	// ****************************************
	// parameter set and menu state
	// ****************************************
	reg  [50:0] par, ed;
	reg  [50:0] next_ed;
	reg  [3:0]  st;
	reg  [4:0]  idle, secs;
	reg  [7:0]  code_sr;
	reg  [2:0]  code_n;
	reg  [2:0]  eidx;
	reg         fac, yes, calibrated, mon_en;
	reg  [7:0]  chal;
	reg  [13:0] cacc;
	reg  [15:0] cal;
	reg  [15:0] cv, lo, hi, nv;

	wire [1:0] bt  = btn_c_i ? 2'h3 : btn_b_i ? 2'h2 :
		btn_a_i ? 2'h1 : 2'h0;
	wire       any = (bt != 2'h0);
	wire [7:0] sr_n = {code_sr[5:0], bt};
	wire [13:0] cacc_fin = cacc + {13'h0000, pedge};
	wire [17:0] cal_x = {4'h0, cacc_fin} * 18'h0000F;
	wire in_menu = (st == S_MAIN) || (st == S_CALCODE) ||
		(st == S_SETSEL) || (st == S_ENGCODE) ||
		(st == S_FACCODE) || (st == S_EDIT) || (st == S_SAVE);

	assign menu_state_o = st;
	assign nv_wr_data_o = par;

	// trip percentage and stop delay limits are wider once factory access is granted
	always @* begin
		cv = 16'h0000;
		lo = 16'h0001;
		hi = 16'h0001;
		next_ed = ed;
		case (eidx)
		3'h0: begin
			cv = {2'h0, ed[`F_SCALE]};
			hi = 16'h270F;
		end
		3'h1, 3'h2, 3'h3, 3'h4: begin
			case (eidx)
			3'h1: cv = {11'h000, ed[`F_UA]};
			3'h2: cv = {11'h000, ed[`F_US]};
			3'h3: cv = {11'h000, ed[`F_OA]};
			default: cv = {11'h000, ed[`F_OS]};
			endcase
			lo = fac ? 16'h0001 : 16'h0005;
			hi = fac ? 16'h001E : 16'h0014;
		end
		3'h5: begin
			cv = {12'h000, ed[`F_OAD]};
			hi = 16'h000A;
		end
		3'h6: begin
			cv = {11'h000, ed[`F_OSD]};
			hi = fac ? 16'h001E : 16'h0014;
		end
		default: begin
			cv = {8'h00, ed[`F_ECODE]};
			lo = 16'h0000;
			hi = 16'h00FF;
		end
		endcase
		nv = cv;
		if (bt == 2'h1 && cv > lo)
			nv = cv - 16'h0001;
		if (bt == 2'h2 && cv < hi)
			nv = cv + 16'h0001;
		case (eidx)
		3'h0: next_ed[`F_SCALE] = nv[13:0];
		3'h1: next_ed[`F_UA] = nv[4:0];
		3'h2: next_ed[`F_US] = nv[4:0];
		3'h3: next_ed[`F_OA] = nv[4:0];
		3'h4: next_ed[`F_OS] = nv[4:0];
		3'h5: next_ed[`F_OAD] = nv[3:0];
		3'h6: next_ed[`F_OSD] = nv[4:0];
		default: next_ed[`F_ECODE] = nv[7:0];
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			st <= S_LOAD;
			par <= {`D_ECODE, `D_OSD, `D_OAD, `D_OS, `D_OA, `D_US,
				`D_UA, `D_SCALE};
			ed <= {`PW{1'b0}};
			idle <= 5'h00;
			secs <= 5'h00;
			code_sr <= 8'h00;
			code_n <= 3'h0;
			eidx <= 3'h0;
			fac <= 1'b0;
			yes <= 1'b0;
			chal <= 8'h01;
			cacc <= 14'h0000;
			cal <= 16'h0000;
			calibrated <= 1'b0;
			cursor_o <= 1'b0;
			nv_wr_o <= 1'b0;
		end else if (ce_i) begin
			nv_wr_o <= 1'b0;
			if (any || !in_menu)
				idle <= 5'h00;
			else if (sec)
				idle <= idle + 5'h01;
			if (any)
				code_sr <= sr_n;
			if (in_menu && sec && idle == `MENU_TMO_S - 5'h01) begin
				st <= S_STATUS;
			end else begin
				case (st)
				S_LOAD: if (nv_valid_i) begin
					if (!nv_blank_i)
						par <= nv_data_i;
					st <= S_STATUS;
				end
				S_STATUS: if (bt == 2'h3) begin
					st <= S_MAIN;
					cursor_o <= 1'b0;
				end
				S_MAIN: begin
					if (bt == 2'h1)
						st <= S_STATUS;
					else if (bt == 2'h2)
						cursor_o <= ~cursor_o;
					else if (bt == 2'h3) begin
						st <= cursor_o ? S_SETSEL : S_CALCODE;
						cursor_o <= 1'b0;
						code_n <= 3'h0;
					end
				end
				S_CALCODE: if (any) begin
					code_n <= code_n + 3'h1;
					if (code_n == 3'h2)
						st <= (sr_n[5:0] == `CAL_CODE) ?
							S_WAIT_IL : S_STATUS;
				end
				S_WAIT_IL: begin
					if (interlock_i) begin
						st <= S_STARTUP;
						secs <= `STARTUP_S;
					end else if (bt == 2'h1)
						st <= S_STATUS;
				end
				S_STARTUP: begin
					if (!interlock_i)
						st <= S_STATUS;
					else if (sec) begin
						secs <= secs - 5'h01;
						if (secs == 5'h01) begin
							st <= S_CALRUN;
							secs <= 5'h00;
							cacc <= 14'h0000;
						end
					end
				end
				S_CALRUN: begin
					if (!interlock_i)
						st <= S_STATUS;
					else if (sec && secs == `CAL_RUN_S - 5'h01) begin
						cal <= cal_x[17:2];
						calibrated <= 1'b1;
						st <= S_STATUS;
					end else begin
						if (pedge)
							cacc <= cacc_fin;
						if (sec)
							secs <= secs + 5'h01;
					end
				end
				S_SETSEL: begin
					if (bt == 2'h1 || bt == 2'h2)
						cursor_o <= ~cursor_o;
					else if (bt == 2'h3) begin
						st <= cursor_o ? S_FACCODE : S_ENGCODE;
						fac <= cursor_o;
						code_n <= 3'h0;
					end
				end
				S_ENGCODE, S_FACCODE: if (any) begin
					code_n <= code_n + 3'h1;
					if (code_n == 3'h3) begin
						ed <= par;
						eidx <= 3'h0;
						if ((st == S_ENGCODE &&
							sr_n == par[`F_ECODE]) ||
							(st == S_FACCODE &&
							sr_n == (chal ^ FAC_KEY)))
							st <= S_EDIT;
						else
							st <= S_STATUS;
					end
				end
				S_EDIT: begin
					if (bt == 2'h3) begin
						if (eidx == (fac ? `IDX_FAC_LAST :
							`IDX_ENG_LAST)) begin
							st <= S_SAVE;
							yes <= 1'b0;
						end else
							eidx <= eidx + 3'h1;
					end else
						ed <= next_ed;
				end
				S_SAVE: begin
					if (bt == 2'h1 || bt == 2'h2)
						yes <= ~yes;
					else if (bt == 2'h3) begin
						if (yes) begin
							par <= ed;
							nv_wr_o <= 1'b1;
							if (fac)
								chal <= chal + 8'h01;
						end
						st <= S_STATUS;
					end
				end
				default: st <= S_STATUS;
				endcase
			end
		end
	end

	// ****************************************
	// supervision
	// ****************************************
	function [15:0] thr;
		input [15:0] c;
		input [7:0]  pct;
		reg   [23:0] p;
		reg   [23:0] q;
		begin
			p = c * pct;
			q = p / 24'h000064;
			thr = q[15:0];
		end
	endfunction

	reg  [4:0]  rs_cnt, os_cnt;
	reg  [3:0]  oa_cnt;
	// thresholds use cal only, never the scale factor
	wire [15:0] th_ua = thr(cal, 8'h64 - {3'h0, par[`F_UA]});
	wire [15:0] th_us = thr(cal, 8'h64 - {3'h0, par[`F_US]});
	wire [15:0] th_oa = thr(cal, 8'h64 + {3'h0, par[`F_OA]});
	wire [15:0] th_os = thr(cal, 8'h64 + {3'h0, par[`F_OS]});
	wire cal_st = (st == S_WAIT_IL) || (st == S_STARTUP) ||
		(st == S_CALRUN);
	wire mon  = calibrated && mon_en && interlock_i && !cal_st &&
		(rs_cnt == 5'h00);
	wire ua_t = mon && (ppm <= th_ua);
	wire us_t = mon && (ppm <= th_us);
	wire oa_t = mon && (ppm >= th_oa);
	wire os_t = mon && (ppm >= th_os);
	wire oa_trip = oa_t && (oa_cnt >= par[`F_OAD]);
	wire os_trip = os_t && (os_cnt >= par[`F_OSD]);

	// ****************************************
	// display scaling
	// ****************************************
	wire [29:0] dprod = {14'h0000, ppm} * {16'h0000, par[`F_SCALE]};
	wire [29:0] dval  = dprod / `SCALE_UNITY;
	// widened so secs*100 keeps its top bits before the divide by 16
	wire [11:0] prog_x = {7'h00, secs} * 12'h064;

	always @(posedge clk_i) begin
		if (rst_i) begin
			rs_cnt <= `STARTUP_S;
			oa_cnt <= 4'h0;
			os_cnt <= 5'h00;
			disp_o <= 14'h0000;
			disp_over_o <= 1'b0;
			alarm_lamp_o <= 1'b0;
			stop_lamp_o <= 1'b0;
			alarm_relay_o <= 1'b0;
			stop_relay_o <= 1'b0;
			progress_o <= 7'h00;
			code_num_o <= 8'h00;
			edit_idx_o <= 3'h0;
			edit_val_o <= 16'h0000;
			save_yes_o <= 1'b0;
		end else if (ce_i) begin
			// start-up grace restarts on every interlock rise
			if (!interlock_i)
				rs_cnt <= `STARTUP_S;
			else if (st == S_CALRUN)
				rs_cnt <= 5'h00;
			else if (sec && rs_cnt != 5'h00)
				rs_cnt <= rs_cnt - 5'h01;
			if (!oa_t)
				oa_cnt <= 4'h0;
			else if (sec && oa_cnt != 4'hF)
				oa_cnt <= oa_cnt + 4'h1;
			if (!os_t)
				os_cnt <= 5'h00;
			else if (sec && os_cnt != 5'h1F)
				os_cnt <= os_cnt + 5'h01;
			disp_over_o <= (dval > {13'h0000, `DISP_MAX});
			disp_o <= (dval > {13'h0000, `DISP_MAX}) ?
				14'h3FFF : dval[13:0];
			alarm_lamp_o <= !calibrated || ua_t || oa_t;
			stop_lamp_o <= us_t || os_t;
			alarm_relay_o <= interlock_i && !ua_t && !oa_trip;
			stop_relay_o <= interlock_i && !us_t && !os_trip;
			progress_o <= (st == S_CALRUN) ?
				prog_x[10:4] : 7'h00;
			code_num_o <= chal;
			edit_idx_o <= eidx;
			edit_val_o <= cv;
			save_yes_o <= yes;
		end
	end

	// ****************************************
	// wishbone slave
	// ****************************************
	wire acc = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			mon_en <= 1'b1;
		end else if (ce_i) begin
			wb_ack_o <= acc;
			wb_dat_o <= 32'h00000000;
			if (acc && wb_we_i && wb_adr_i == `R_CTRL && wb_sel_i[0])
				mon_en <= wb_dat_i[0];
			if (acc && !wb_we_i) begin
				case (wb_adr_i)
				`R_STATUS: wb_dat_o <= {20'h00000, st,
					calibrated, mon, alarm_lamp_o, stop_lamp_o,
					alarm_relay_o, stop_relay_o, disp_over_o,
					mon_en};
				`R_SPEED: wb_dat_o <= {16'h0000, ppm};
				`R_DISPLAY: wb_dat_o <= {18'h00000, disp_o};
				`R_CALSPEED: wb_dat_o <= {16'h0000, cal};
				`R_CTRL: wb_dat_o <= {31'h00000000, mon_en};
				`R_PAR_LO: wb_dat_o <= par[31:0];
				`R_PAR_HI: wb_dat_o <= {13'h0000, par[50:32]};
				default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

// [design/elevator_speed_supervisor_defines.vh]
// constants for the elevator speed supervisor
// assumes a 250 MHz system clock and one-cycle button touches
`ifndef ELEVATOR_SPEED_SUPERVISOR_DEFINES_VH
`define ELEVATOR_SPEED_SUPERVISOR_DEFINES_VH

// ****************************************
// timing
// ****************************************
`define CLK_MHZ      250
`define SEC_CYCLES   (`CLK_MHZ * 1000000)
`define MENU_TMO_S   5'h1E
`define CAL_RUN_S    5'h10
`define STARTUP_S    5'h0A
`define PPM_PER_PPS  16'h003C
`define SCALE_UNITY  30'h000004B0
`define DISP_MAX     17'h0270F

// ****************************************
// parameter set layout
// ****************************************
`define PW           51
`define F_SCALE      13:0
`define F_UA         18:14
`define F_US         23:19
`define F_OA         28:24
`define F_OS         33:29
`define F_OAD        37:34
`define F_OSD        42:38
`define F_ECODE      50:43
`define D_SCALE      14'h04B0
`define D_UA         5'h0A
`define D_US         5'h14
`define D_OA         5'h0A
`define D_OS         5'h14
`define D_OAD        4'hA
`define D_OSD        5'h14
`define D_ECODE      8'hAA

// ****************************************
// codes and limits
// ****************************************
`define CAL_CODE     6'h1B
`define IDX_ENG_LAST 3'h6
`define IDX_FAC_LAST 3'h7

// ****************************************
// register offsets
// ****************************************
`define R_STATUS     8'h00
`define R_SPEED      8'h04
`define R_DISPLAY    8'h08
`define R_CALSPEED   8'h0C
`define R_CTRL       8'h10
`define R_PAR_LO     8'h14
`define R_PAR_HI     8'h18
`endif

// [testbench/elevator_speed_supervisor_monitor.sv]
// checker bound to the speed supervisor top level ports
// assumes one clock, synchronous active high reset, ce_i held high
module elevator_speed_supervisor_monitor (
	input wire        clk_i,
	input wire        rst_i,
	input wire        ce_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_ack_o,
	input wire [31:0] wb_dat_o,
	input wire        btn_a_i,
	input wire        btn_b_i,
	input wire        btn_c_i,
	input wire        interlock_i,
	input wire        nv_valid_i,
	input wire        nv_wr_o,
	input wire [13:0] disp_o,
	input wire        disp_over_o,
	input wire [3:0]  menu_state_o,
	input wire [6:0]  progress_o,
	input wire        alarm_relay_o,
	input wire        stop_relay_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ********************
	// bus handshake
	// ********************
	sequence bus_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
	endsequence
	sequence one_ack;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	chk_bus_answer: assert property (bus_req |=> one_ack)
		else $error("bus request without a single ack");
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside the ack cycle");
	// ********************
	// menu and supervision
	// ********************
	chk_load_exit: assert property (
		menu_state_o == 4'h0 && nv_valid_i && ce_i |=> menu_state_o == 4'h1)
		else $error("stored set not taken at power-up");
	chk_menu_open: assert property (
		menu_state_o == 4'h1 && btn_c_i && ce_i |=> menu_state_o == 4'h2)
		else $error("button C did not open the menu");
	chk_menu_abort: assert property (
		menu_state_o == 4'h2 && btn_a_i && !btn_b_i && !btn_c_i && ce_i
		|=> menu_state_o == 4'h1)
		else $error("button A did not leave the menu");
	chk_over_dash: assert property (disp_over_o |-> disp_o == 14'h3FFF)
		else $error("overrange without the dash pattern");
	chk_relay_drop: assert property (
		ce_i && !interlock_i |=> !alarm_relay_o && !stop_relay_o)
		else $error("relay held without interlock");
	chk_prog_idle: assert property (
		menu_state_o != 4'h6 && $past(menu_state_o) != 4'h6
		|-> progress_o == 7'h0)
		else $error("progress shown outside calibration");
	chk_save_write: assert property (
		nv_wr_o |-> $past(menu_state_o) == 4'hB && $past(btn_c_i))
		else $error("store written without a save");
endmodule
bind elevator_speed_supervisor elevator_speed_supervisor_monitor u_mon (
	.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
	.btn_a_i, .btn_b_i, .btn_c_i, .interlock_i, .nv_valid_i, .nv_wr_o,
	.disp_o, .disp_over_o, .menu_state_o, .progress_o, .alarm_relay_o,
	.stop_relay_o);

// [testbench/probe_partner.sv]
// probe and starter interlock model facing the speed supervisor
// assumes the bench sets motor state and probe toggle spacing
module probe_partner (
	input  wire logic       clk_i,
	input  wire logic       motor_i,
	input  wire logic [3:0] half_i,
	output logic            probe_o,
	output logic            interlock_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt = 4'h0;
	// the starter gives the interlock only while the motor runs
	assign interlock_o = motor_i;
	initial probe_o = 1'b0;
	// a stopped belt gives no probe edges
	always @(posedge clk_i) begin
		if (!motor_i) begin
			cnt <= 4'h0;
		end else if (cnt == half_i - 4'h1) begin
			cnt <= 4'h0;
			probe_o <= ~probe_o;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule

// [testbench/elevator_speed_supervisor_test.sv]
// self-checking bench for the elevator speed supervisor
// assumes the design, its checker and the probe model compiled first
`include "elevator_speed_supervisor_defines.vh"
module elevator_speed_supervisor_test;
	timeunit 1ns;
	timeprecision 1ps;
	// ********************
	// wiring
	// ********************
	// short second keeps the run small; all delays scale with it
	localparam int T = 120;
	localparam logic [50:0] STORED = {`D_ECODE, `D_OSD, 4'h5, `D_OS,
		`D_OA, `D_US, `D_UA, `D_SCALE};
	localparam logic [50:0] DFLT = {`D_ECODE, `D_OSD, `D_OAD, `D_OS,
		`D_OA, `D_US, `D_UA, `D_SCALE};
	logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, motor = 1'b0;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00, code_num_o;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic [3:0]  wb_sel_i = 4'h0, half = 4'hC, menu_state_o;
	logic [2:0]  btn = 3'h0, edit_idx_o;
	logic        nv_valid_i = 1'b1, btn_a_i, btn_b_i, btn_c_i, probe_i;
	logic        nv_blank = 1'b0;
	logic [50:0] nv_data = STORED;
	logic        interlock_i, wb_ack_o, nv_wr_o, disp_over_o, cursor_o;
	logic        save_yes_o, alarm_lamp_o, stop_lamp_o;
	logic        alarm_relay_o, stop_relay_o;
	logic [50:0] nv_wr_data_o;
	logic [13:0] disp_o;
	logic [15:0] edit_val_o;
	logic [6:0]  progress_o;
	int          fail_count = 0, comparisons = 0;
	assign {btn_c_i, btn_b_i, btn_a_i} = btn;
	always #2 clk_i = ~clk_i;
	elevator_speed_supervisor #(.TICKS_PER_SEC(T)) u_dut (.clk_i, .rst_i,
		.ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
		.wb_sel_i, .wb_dat_o, .wb_ack_o, .btn_a_i, .btn_b_i, .btn_c_i,
		.probe_i, .interlock_i, .nv_valid_i, .nv_blank_i(nv_blank),
		.nv_data_i(nv_data), .nv_wr_o, .nv_wr_data_o, .disp_o, .disp_over_o,
		.menu_state_o, .cursor_o, .code_num_o, .edit_idx_o, .edit_val_o,
		.save_yes_o, .progress_o, .alarm_lamp_o, .stop_lamp_o,
		.alarm_relay_o, .stop_relay_o);
	probe_partner u_far (.clk_i, .motor_i(motor), .half_i(half),
		.probe_o(probe_i), .interlock_o(interlock_i));
	// ********************
	// shared tasks
	// ********************
	task automatic check(input string name, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic hang();
		fail_count++;
		$display("mismatch wait expected done seen timeout");
		give_verdict();
	endtask
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hF};
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20)
			hang();
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task automatic keys(input string s);
		for (int i = 0; i < s.len(); i++) begin
			@(posedge clk_i);
			btn <= s[i] == "A" ? 3'b001 : s[i] == "B" ? 3'b010 : 3'b100;
			@(posedge clk_i);
			btn <= 3'b000;
			repeat (2) @(posedge clk_i);
		end
	endtask
	function automatic logic cond(input int k, input logic [3:0] st);
		case (k)
			0: return menu_state_o === st;
			1: return alarm_lamp_o === 1'b1;
			2: return alarm_relay_o === 1'b0;
			default: return stop_relay_o === 1'b0;
		endcase
	endfunction
	task automatic wait_for(input int k, input logic [3:0] st, input int lim,
		output int n);
		n = 0;
		while (!cond(k, st) && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= lim)
			hang();
	endtask
	task automatic setup(input logic c);
		keys("CBC");
		check("state", menu_state_o, 4'h7);
		if (cursor_o !== c)
			keys("B");
		keys("C");
	endtask
	// ********************
	// scenarios
	// ********************
	task automatic t_load();
		int n;
		wait_for(0, 4'h1, 10, n);
		check("par_lo", nv_wr_data_o[31:0], STORED[31:0]);
		check("par_hi", nv_wr_data_o[50:32], STORED[50:32]);
		bus(1'b0, `R_PAR_HI, 32'h0);
		check("reg_par_hi", rd, {13'h0, STORED[50:32]});
		bus(1'b0, `R_STATUS, 32'h0);
		check("status", rd[11:0], 12'h121);
		bus(1'b1, 8'h20, 32'hFFFFFFFF);
		bus(1'b0, 8'h20, 32'h0);
		check("unmapped", rd, 32'h0);
		// a touch while frozen must be lost
		ce_i <= 1'b0;
		keys("C");
		check("frozen", menu_state_o, 4'h1);
		ce_i <= 1'b1;
	endtask
	task automatic t_menu();
		keys("C");
		check("state", menu_state_o, 4'h2);
		check("cursor", cursor_o, 1'b0);
		keys("A");
		check("state", menu_state_o, 4'h1);
		setup(1'b0);
		check("state", menu_state_o, 4'h8);
		keys("ABBB");
		check("state", menu_state_o, 4'h1);
		for (int y = 0; y < 2; y++) begin
			setup(1'b0);
			keys("BBBB");
			check("index", edit_idx_o, 3'h0);
			check("scale", edit_val_o, 16'h04B0);
			keys("B");
			check("scale", edit_val_o, 16'h04B1);
			keys("CCCCCCC");
			check("state", menu_state_o, 4'hB);
			if (y == 1)
				keys("B");
			check("answer", save_yes_o, y[0]);
			keys("C");
			check("state", menu_state_o, 4'h1);
			check("saved", nv_wr_data_o[13:0], y ? 14'h04B1 : 14'h04B0);
		end
	endtask
	task automatic t_factory();
		int n;
		setup(1'b1);
		check("state", menu_state_o, 4'h9);
		check("challenge", code_num_o, 8'h01);
		keys("AABC");
		check("state", menu_state_o, 4'hA);
		keys("CCCCCCCC");
		check("state", menu_state_o, 4'hB);
		keys("C");
		setup(1'b1);
		keys("AABC");
		check("state", menu_state_o, 4'hA);
		keys("CCCCCCC");
		check("index", edit_idx_o, 3'h7);
		keys("BCBC");
		check("ecode", nv_wr_data_o[50:43], 8'hAB);
		check("challenge", code_num_o, 8'h02);
		setup(1'b1);
		keys("AABC");
		check("state", menu_state_o, 4'h1);
		setup(1'b1);
		wait_for(0, 4'h1, 31 * T, n);
		check("idle", n >= 29 * T, 1'b1);
	endtask
	task automatic t_cal();
		int n;
		keys("CC");
		check("state", menu_state_o, 4'h3);
		keys("ABC");
		check("state", menu_state_o, 4'h4);
		motor <= 1'b1;
		wait_for(0, 4'h5, 8, n);
		motor <= 1'b0;
		wait_for(0, 4'h1, 8, n);
		repeat (2) @(posedge clk_i);
		check("relays", {alarm_relay_o, stop_relay_o}, 2'b00);
		bus(1'b0, `R_CALSPEED, 32'h0);
		check("cal", rd, 32'h0);
		keys("CCABC");
		motor <= 1'b1;
		wait_for(0, 4'h6, 11 * T, n);
		check("startup", n >= 9 * T, 1'b1);
		wait_for(0, 4'h1, 17 * T, n);
		check("cal_run", n >= 15 * T, 1'b1);
		bus(1'b0, `R_CALSPEED, 32'h0);
		check("cal", rd, 32'h12C);
		repeat (2 * T) @(posedge clk_i);
		check("display", disp_o, 14'h012C);
	endtask
	task automatic t_trips();
		int n, m;
		// exactly the underspeed stop level: reaching it trips
		half <= 4'hF;
		wait_for(1, 4'h0, 3 * T, n);
		repeat (2) @(posedge clk_i);
		check("under", {stop_lamp_o, alarm_relay_o, stop_relay_o}, 3'h4);
		half <= 4'hC;
		motor <= 1'b0;
		repeat (4) @(posedge clk_i);
		motor <= 1'b1;
		repeat (11 * T) @(posedge clk_i);
		check("normal", {alarm_lamp_o, stop_lamp_o, alarm_relay_o,
			stop_relay_o}, 4'h3);
		half <= 4'hA;
		wait_for(1, 4'h0, 3 * T, n);
		repeat (2) @(posedge clk_i);
		check("over", {stop_lamp_o, alarm_relay_o, stop_relay_o}, 3'h7);
		wait_for(2, 4'h0, 7 * T, n);
		check("ovs_alarm", n >= 4 * T, 1'b1);
		wait_for(3, 4'h0, 17 * T, m);
		check("ovs_stop", n + m >= 19 * T, 1'b1);
	endtask
	task automatic t_abort();
		int n;
		keys("CCABC");
		wait_for(0, 4'h6, 11 * T, n);
		repeat (8 * T + T / 2) @(posedge clk_i);
		check("progress", progress_o, 7'h32);
		motor <= 1'b0;
		wait_for(0, 4'h1, 8, n);
		bus(1'b0, `R_CALSPEED, 32'h0);
		check("cal_kept", rd, 32'h12C);
	endtask
	task automatic t_blank();
		int n;
		rst_i <= 1'b1;
		nv_blank <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_for(0, 4'h1, 10, n);
		check("dflt_lo", nv_wr_data_o[31:0], DFLT[31:0]);
		check("dflt_hi", nv_wr_data_o[50:32], DFLT[50:32]);
		// full scale on a fast belt must run past four digits
		rst_i <= 1'b1;
		nv_blank <= 1'b0;
		nv_data[13:0] <= 14'h270F;
		{motor, half} <= {1'b1, 4'h1};
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3 * T) @(posedge clk_i);
		check("overrange", {disp_over_o, disp_o}, 15'h7FFF);
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_load();
		t_menu();
		t_factory();
		t_cal();
		t_trips();
		t_abort();
		t_blank();
		give_verdict();
	end
endmodule
